// ### verilog/dng_nmi_map.vh
// register map, field positions and scan timing for the display interrupt generator
`ifndef DNG_NMI_MAP_VH
`define DNG_NMI_MAP_VH

// apb byte addresses
`define DNG_ADDR_ENABLE    8'h00
`define DNG_ADDR_STATUS    8'h04
`define DNG_ADDR_CLEAR     8'h08
`define DNG_ADDR_VSCROLL   8'h0C

// status field positions; the enable register takes frame from bit 7 and line from bit 6
`define DNG_BIT_RESET      5
`define DNG_BIT_FRAME      6
`define DNG_BIT_LINE       7

// display instruction fields
`define DNG_INS_LINE_IRQ   7
`define DNG_INS_JUMP_WAIT  6
`define DNG_INS_SCROLL     5
`define DNG_INS_MODE_BLANK 4'h0
`define DNG_INS_MODE_JUMP  4'h1

// scan timing, in display cycles within a line; the frame-end line in scan lines
`define DNG_CYC_SCROLL_DLI 7'h05
`define DNG_CYC_STATUS     7'h07
`define DNG_CYC_FIRE       7'h08
`define DNG_CYC_FIRE_LATE  7'h09
`define DNG_CYC_LINE_END   7'h6C
`define DNG_LINE_VBLANK    9'h0F8

// reset values
`define DNG_ENABLE_RST     2'h0
`define DNG_STATUS_RST     3'h0
`define DNG_VSCROLL_RST    4'h0
`define DNG_ROW_RST        4'h0

`endif

// ### verilog/dng_nmi_pulse.v
// stretches a one-cycle fire request into an active-low interrupt line pulse
`timescale 1ns/1ns

module dng_nmi_pulse
#(
	parameter WIDTH = 4	// cycles the line is held low
)
(
	input  wire clk,
	input  wire rst,
	input  wire fire,
	output reg  nmiN
);

	reg [7:0] holdCount;	// cycles of low level still to go

	// a new fire restarts the hold so back-to-back events never merge early
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			holdCount <= 8'h00;
			nmiN      <= 1'b1;
		end
		else if (fire)
		begin
			holdCount <= WIDTH[7:0] - 8'h01;
			nmiN      <= 1'b0;
		end
		else if (holdCount != 8'h00)
		begin
			holdCount <= holdCount - 8'h01;
			nmiN      <= 1'b0;
		end
		else
			nmiN <= 1'b1;
	end

endmodule

// ### verilog/dng_nmi_gen.v
// display-list driven non-maskable interrupt generator with apb registers
`timescale 1ns/1ns
`include "dng_nmi_map.vh"

module dng_nmi_gen
#(
	parameter NMI_WIDTH = 4	// cycles the interrupt line stays low
)
(
	input  wire        clk,
	input  wire        rst,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// display timing
	input  wire [6:0]  hPos,
	input  wire [8:0]  vPos,
	input  wire        modeLoad,
	input  wire [7:0]  displayInstruction,
	input  wire [3:0]  modeRows,
	// host and system
	input  wire        irqAckBusy,
	input  wire        resetButton,
	output reg         modeLineEnd,
	output reg  [3:0]  rowCount,
	output wire        nmiN
);

	// registers
	reg  [1:0] enableBits;	// [1] frame, [0] line
	reg  [2:0] status;	// [2] line, [1] frame, [0] reset
	reg  [3:0] verticalScrollRow;	// scroll register
	reg        curScroll;	// scroll bit of current mode line
	reg        scrollEnding;	// this mode line closes a scrolled region
	reg        lineIrqFlag;	// current instruction asks for line irq
	reg        waitJump;	// wait-for-frame jump in progress
	reg        lineDecided;	// line irq decided for this scan line
	reg        lineDue;	// line irq owed at cycle 8
	reg        frameDue;	// frame irq owed at cycle 8
	reg        resetDue;	// reset-button irq owed at cycle 8
	reg        enabledAt7;	// an enable bit was newly set at cycle 7
	reg        lateFire;	// fire postponed to cycle 9

	// apb decode
	wire       wrXfer;	// write taken at this edge
	wire       setupRd;	// read setup cycle
	wire       hitEnable;
	wire       hitStatus;
	wire       hitClear;
	wire       hitScroll;
	wire       mapped;
	reg  [1:0] next_enableBits;	// enable value including a write now
	reg  [3:0] next_verticalScrollRow;
	wire [3:0] endRow;	// row that closes this mode line, decide time
	wire [3:0] endRowLate;	// same with late scroll writes
	wire       lastAtDecide;
	wire       lastAtEnd;
	wire       fireNow;
	wire       fireLate;
	wire       fire;
	wire       clearWrite;
	wire       insBlank;
	wire       insScroll;

	assign hitEnable = (paddr == `DNG_ADDR_ENABLE);
	assign hitStatus = (paddr == `DNG_ADDR_STATUS);
	assign hitClear  = (paddr == `DNG_ADDR_CLEAR);
	assign hitScroll = (paddr == `DNG_ADDR_VSCROLL);
	assign mapped    = hitEnable | hitStatus | hitClear | hitScroll;

	// zero wait states: every access phase completes
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign wrXfer  = psel & penable & pwrite & mapped;
	assign setupRd = psel & ~penable & ~pwrite;
	assign clearWrite = wrXfer & hitClear;

	// values the registers take at this edge, used by deadlines
	always @*
	begin
		next_enableBits = enableBits;
		next_verticalScrollRow = verticalScrollRow;
		if (wrXfer & hitEnable)
			next_enableBits = {pwdata[`DNG_BIT_FRAME + 1], pwdata[`DNG_BIT_LINE - 1]};
		if (wrXfer & hitScroll)
			next_verticalScrollRow = pwdata[3:0];
	end

	// read data is captured in the setup cycle so it stands during access
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			prdata <= 32'h00000000;
		else if (setupRd)
		begin
			if (paddr == `DNG_ADDR_STATUS)
				prdata <= {24'h000000, status, 5'h00};
			else if (paddr == `DNG_ADDR_VSCROLL)
				prdata <= {28'h0000000, verticalScrollRow};
			else
				prdata <= 32'h00000000;	// write-only and unmapped read zero
		end
	end

	// software-written control
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			enableBits        <= `DNG_ENABLE_RST;
			verticalScrollRow <= `DNG_VSCROLL_RST;
		end
		else
		begin
			enableBits        <= next_enableBits;
			verticalScrollRow <= next_verticalScrollRow;
		end
	end

	// instruction decode: blank lines reuse the scroll bit as a count
	assign insBlank  = (displayInstruction[3:0] == `DNG_INS_MODE_BLANK);
	assign insScroll = displayInstruction[`DNG_INS_SCROLL] & ~insBlank;

	// closing row: the scroll value when leaving a scrolled region
	assign endRow     = scrollEnding ? next_verticalScrollRow : modeRows;
	assign endRowLate = scrollEnding ? next_verticalScrollRow : modeRows;
	assign lastAtDecide = (rowCount == endRow);
	assign lastAtEnd    = (rowCount == endRowLate);

	// mode line tracking and row counter
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rowCount     <= `DNG_ROW_RST;
			curScroll    <= 1'b0;
			scrollEnding <= 1'b0;
			lineIrqFlag  <= 1'b0;
			waitJump     <= 1'b0;
			modeLineEnd  <= 1'b0;
		end
		else if (modeLoad)
		begin
			// entering a scrolled region starts mid-way
			rowCount     <= (insScroll & ~curScroll) ? next_verticalScrollRow : `DNG_ROW_RST;
			curScroll    <= insScroll;
			scrollEnding <= curScroll & ~insScroll;
			lineIrqFlag  <= displayInstruction[`DNG_INS_LINE_IRQ];
			waitJump     <= (displayInstruction[3:0] == `DNG_INS_MODE_JUMP) &
			                displayInstruction[`DNG_INS_JUMP_WAIT];
			modeLineEnd  <= 1'b0;
		end
		else
		begin
			if (vPos == `DNG_LINE_VBLANK)
				waitJump <= 1'b0;
			if (hPos == `DNG_CYC_LINE_END)
			begin
				// height follows the scroll value even after the irq deadline
				modeLineEnd <= lastAtEnd & ~waitJump;
				if (!lastAtEnd)
					rowCount <= rowCount + 4'h1;
			end
		end
	end

	// line irq decision made early, frozen until it is cleared at cycle 9
	// a finished mode line with no new instruction yet must not fire again
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			lineDecided <= 1'b0;
		else if (hPos == `DNG_CYC_SCROLL_DLI)
			lineDecided <= lineIrqFlag & ~modeLineEnd & (waitJump | lastAtDecide) &
			               (vPos < `DNG_LINE_VBLANK);
		else if (hPos == `DNG_CYC_FIRE_LATE)
			lineDecided <= 1'b0;
	end

	// status flags: hardware set wins over a concurrent clear
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			status <= `DNG_STATUS_RST;
		else
		begin
			if (clearWrite)
				status <= `DNG_STATUS_RST;
			if (hPos == `DNG_CYC_STATUS && vPos == `DNG_LINE_VBLANK)
			begin
				status[1] <= 1'b1;
				status[2] <= 1'b0;
			end
			else if (hPos == `DNG_CYC_STATUS && lineDecided)
			begin
				status[2] <= 1'b1;
				status[1] <= 1'b0;
			end
			if (resetButton)
				status[0] <= 1'b1;
		end
	end

	// owed interrupts live apart from status so a clear cannot cancel them
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lineDue  <= 1'b0;
			frameDue <= 1'b0;
			resetDue <= 1'b0;
		end
		else
		begin
			if (hPos == `DNG_CYC_STATUS)
			begin
				frameDue <= (vPos == `DNG_LINE_VBLANK);
				lineDue  <= lineDecided & (vPos != `DNG_LINE_VBLANK);
			end
			else if (hPos == `DNG_CYC_FIRE_LATE)
			begin
				frameDue <= 1'b0;
				lineDue  <= 1'b0;
			end
			if (resetButton)
				resetDue <= 1'b1;
			else if (hPos == `DNG_CYC_FIRE)
				resetDue <= 1'b0;
		end
	end

	// a bit newly set by a write landing in cycle 7 pushes a frame or line fire out to cycle 9 and drops a reset fire
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			enabledAt7 <= 1'b0;
		else if (hPos == `DNG_CYC_STATUS)
			enabledAt7 <= wrXfer & hitEnable &
			              ((next_enableBits & ~enableBits) != 2'h0);
		else if (hPos == `DNG_CYC_FIRE_LATE)
			enabledAt7 <= 1'b0;
	end

	// fire at cycle 8; the enable seen includes a disable written in cycle 8
	assign fireNow = (hPos == `DNG_CYC_FIRE) & ~enabledAt7 &
	                 ((frameDue & next_enableBits[1]) |
	                  (lineDue & next_enableBits[0]) | resetDue);

	assign fireLate = lateFire &
	                  ((frameDue & next_enableBits[1]) |
	                   (lineDue & next_enableBits[0]));

	// delayed fire is armed at cycle 8 and used at cycle 9
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			lateFire <= 1'b0;
		else
			lateFire <= (hPos == `DNG_CYC_FIRE) & enabledAt7;
	end

	// an irq acknowledge on the host swallows the pulse; status already kept
	assign fire = (fireNow | fireLate) & ~irqAckBusy;

	// interrupt line driver
	dng_nmi_pulse
	#(
		.WIDTH (NMI_WIDTH)
	)
	u_pulse
	(
		.clk  (clk),
		.rst  (rst),
		.fire (fire),
		.nmiN (nmiN)
	);

endmodule

// ### dv/dng_nmi_gen_asserts.sv
// port-level checks on the display interrupt generator
`timescale 1ns/1ns
module dng_nmi_gen_asserts
#(
	parameter int NMI_WIDTH = 4	// low time of the line
)
(
	input logic        clk,
	input logic        rst,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pslverr,
	input logic [6:0]  hPos,
	input logic [8:0]  vPos,
	input logic        irqAckBusy,
	input logic        nmiN
);
	reg [1:0] en;	// shadow of enable bits
	reg [3:0] sc;	// shadow of scroll row
	// shadows follow completed apb writes
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			en <= 2'h0;
			sc <= 4'h0;
		end
		else if (psel && penable && pwrite)
		begin
			if (paddr == 8'h00) en <= pwdata[7:6];
			if (paddr == 8'h0C) sc <= pwdata[3:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_fire_hpos: assert property ($fell(nmiN) |->
		hPos == 7'h09 || hPos == 7'h0A)
		else $error("interrupt line fell at wrong cycle");
	a_pulse_width: assert property ($fell(nmiN) |-> ##NMI_WIDTH nmiN && $past(!nmiN))
		else $error("interrupt pulse width wrong");
	a_frame_fire: assert property (vPos == 9'h0F8 && hPos == 7'h08 && en[1]
		&& !irqAckBusy |=> !nmiN)
		else $error("frame interrupt missing");
	a_lost_ack: assert property (hPos == 7'h08 && irqAckBusy && nmiN |=> nmiN)
		else $error("interrupt fired during acknowledge");
	a_err_map: assert property (psel && penable |->
		pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h0C))
		else $error("slave error flag wrong");
	a_status_excl: assert property (psel && penable && !pwrite && paddr == 8'h04
		|-> !(prdata[7] && prdata[6]))
		else $error("line and frame status both set");
	a_wo_read_zero: assert property (psel && penable && !pwrite
		&& (paddr == 8'h00 || paddr == 8'h08) |-> prdata == 32'h0)
		else $error("write-only register read nonzero");
	a_scroll_rw: assert property (psel && penable && !pwrite && paddr == 8'h0C
		|-> prdata == {28'h0, sc})
		else $error("scroll row readback wrong");
endmodule
bind dng_nmi_gen dng_nmi_gen_asserts #(.NMI_WIDTH(NMI_WIDTH)) dng_nmi_gen_asserts_inst
(
	.clk        (clk),
	.rst        (rst),
	.psel       (psel),
	.penable    (penable),
	.pwrite     (pwrite),
	.paddr      (paddr),
	.pwdata     (pwdata),
	.prdata     (prdata),
	.pslverr    (pslverr),
	.hPos       (hPos),
	.vPos       (vPos),
	.irqAckBusy (irqAckBusy),
	.nmiN       (nmiN)
);

// ### dv/dng_host_model.sv
// host model: counts interrupt entries and stages an irq acknowledge
`timescale 1ns/1ns
module dng_host_model
(
	input  wire       clk,
	input  wire       rst,
	input  wire       nmiN,
	input  wire [6:0] hPos,
	input  wire       ackReq,
	output reg        irqAckBusy,
	output reg  [7:0] nmiSeen
);
	reg nmiQ;	// line seen one cycle late
	// edge detect of the line, ack window over cycles 4-10
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			nmiQ <= 1'b1;
			nmiSeen <= 8'h00;
			irqAckBusy <= 1'b0;
		end
		else
		begin
			nmiQ <= nmiN;
			if (nmiQ && !nmiN) nmiSeen <= nmiSeen + 8'h01;
			irqAckBusy <= ackReq && hPos >= 7'h03 && hPos <= 7'h09;
		end
	end
endmodule

// ### dv/dng_nmi_gen_tb.sv
// self-checking bench for the display interrupt generator
`timescale 1ns/1ns
module dng_nmi_gen_tb;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0;
	reg  [6:0]  hPos = 7'h00;	// scan cycle
	reg  [8:0]  vPos = 9'h0EE;	// start near frame end
	reg         modeLoad = 1'b0;
	reg  [7:0]  displayInstruction = 8'h00;
	reg         resetButton = 1'b0;
	reg         ackReq = 1'b0;
	reg  [3:0]  modeRows = 4'h0;	// rows-1 of the current mode line
	reg         rerr;	// slave error seen at the access edge
	wire [31:0] prdata;
	wire        pready, pslverr, irqAckBusy, nmiN, modeLineEnd;
	wire [3:0]  rowCount;
	wire [7:0]  nmiSeen;
	integer     errCount = 0, nTests = 0, cycles = 0;
	reg  [31:0] rdata;
	reg  [7:0]  base;

	always #25 clk = ~clk;
	// scan position, 114 cycles a line; the bench frame wraps back early
	// so a second frame starts soon after the frame-end line; hang guard last
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (!rst)
		begin
			hPos <= (hPos == 7'h71) ? 7'h00 : hPos + 7'h01;
			if (hPos == 7'h71)
				vPos <= (vPos == 9'h0F9) ? 9'h0E0 : vPos + 9'h001;
		end
		if (cycles == 6000)
		begin
			errCount = errCount + 1;
			results;
		end
	end

	dng_nmi_gen dng_nmi_gen_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hPos(hPos), .vPos(vPos), .modeLoad(modeLoad),
		.displayInstruction(displayInstruction), .modeRows(modeRows), .irqAckBusy(irqAckBusy),
		.resetButton(resetButton), .modeLineEnd(modeLineEnd), .rowCount(rowCount), .nmiN(nmiN));
	dng_host_model dng_host_model_inst (.clk(clk), .rst(rst), .nmiN(nmiN), .hPos(hPos),
		.ackReq(ackReq), .irqAckBusy(irqAckBusy), .nmiSeen(nmiSeen));

	task results;
	begin
		if (errCount == 0 && nTests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	task check(input [31:0] got, input [31:0] exp);
	begin
		nTests = nTests + 1;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			errCount = errCount + 1;
		end
	end
	endtask
	// one apb transfer, held until pready
	task apb(input w, input [7:0] a, input [31:0] d);
	begin
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	task rd(input [7:0] a, input [31:0] exp);
	begin
		apb(1'b0, a, 32'h0);
		check(rdata, exp);
	end
	endtask
	// sampled off the edge so counters have settled
	task at(input [8:0] v, input [6:0] h);
	begin
		@(negedge clk);
		while (vPos != v || hPos != h)
			@(negedge clk);
	end
	endtask
	task load(input [8:0] v, input [7:0] ins, input [3:0] rows);
	begin
		at(v, 7'h00);
		@(posedge clk);
		modeLoad <= 1'b1;
		displayInstruction <= ins;
		modeRows <= rows;
		@(posedge clk);
		modeLoad <= 1'b0;
		base = nmiSeen;
	end
	endtask

	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(8'h04, 32'h0);
		rd(8'h00, 32'h0);
		apb(1'b1, 8'h0C, 32'h1D);
		rd(8'h0C, 32'hD);
		rd(8'h10, 32'h0);
		check({31'h0, rerr}, 32'h1);
		base = nmiSeen;
		@(posedge clk);
		resetButton <= 1'b1;
		@(posedge clk);
		resetButton <= 1'b0;
		at(9'h0F0, 7'h14);
		check(nmiSeen, base + 8'h01);
		rd(8'h04, 32'h20);
		apb(1'b1, 8'h08, 32'h0);
		rd(8'h04, 32'h0);
		load(9'h0F1, 8'h82, 4'h0);
		at(9'h0F1, 7'h14);
		check(nmiSeen, base);
		rd(8'h04, 32'h80);
		apb(1'b1, 8'h00, 32'hC0);
		load(9'h0F2, 8'hC1, 4'h0);
		at(9'h0F8, 7'h14);
		check(nmiSeen, base + 8'h07);
		rd(8'h04, 32'h40);
		// second bench frame: display lines again before the frame-end line
		load(9'h0E0, 8'h82, 4'h0);
		at(9'h0E0, 7'h09);
		check({31'h0, nmiN}, 32'h0);
		at(9'h0E0, 7'h14);
		check(nmiSeen, base + 8'h01);
		rd(8'h04, 32'h80);
		apb(1'b1, 8'h08, 32'hFF);
		ackReq <= 1'b1;
		load(9'h0E2, 8'h82, 4'h0);
		at(9'h0E2, 7'h14);
		check(nmiSeen, base);
		rd(8'h04, 32'h80);
		ackReq <= 1'b0;
		apb(1'b1, 8'h00, 32'h0);
		// enable written so that it lands exactly in cycle 7
		load(9'h0E4, 8'h82, 4'h0);
		at(9'h0E4, 7'h05);
		apb(1'b1, 8'h00, 32'h40);
		at(9'h0E4, 7'h09);
		check({31'h0, nmiN}, 32'h1);
		at(9'h0E4, 7'h0A);
		check({31'h0, nmiN}, 32'h0);
		// scrolled region entered at row 5, left with a late scroll write
		apb(1'b1, 8'h0C, 32'h5);
		load(9'h0E6, 8'hA2, 4'h7);
		apb(1'b1, 8'h0C, 32'h2);
		at(9'h0E6, 7'h14);
		check({28'h0, rowCount}, 32'h5);
		at(9'h0E8, 7'h14);
		check(nmiSeen, base + 8'h01);
		at(9'h0E8, 7'h70);
		check({31'h0, modeLineEnd}, 32'h1);
		load(9'h0E9, 8'h82, 4'h7);
		at(9'h0EA, 7'h06);
		apb(1'b1, 8'h0C, 32'h1);
		at(9'h0EA, 7'h70);
		check({31'h0, modeLineEnd}, 32'h1);
		check(nmiSeen, base);
		// blank line with the scroll bit never starts a region
		load(9'h0EC, 8'hA0, 4'h0);
		at(9'h0EC, 7'h14);
		check({28'h0, rowCount}, 32'h0);
		check(nmiSeen, base + 8'h01);
		results;
	end
endmodule
